// ==== rtl/tpwm_consts.svh ====
// Purpose: register indices, field positions, reset values and codes of the 8-bit timers
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH

`define IDX_TIMER_A_BOUND 8'h09
`define IDX_TIMER_A_DIVIDER 8'h17
`define IDX_TIMER_A_CONTROL 8'h1C
`define IDX_TIMER_A_COUNT 8'h1D
`define IDX_TIMER_B_CONTROL 8'h32
`define IDX_TIMER_B_COUNT 8'h33
`define IDX_TIMER_B_DIVIDER 8'h34
`define IDX_TIMER_B_BOUND 8'h35

`define RST_BYTE 8'h00

`define CTL_SRC_HI 7
`define CTL_SRC_LO 4
`define CTL_ROUTE_HI 3
`define CTL_ROUTE_LO 2
`define CTL_MODE 1
`define CTL_INVERT 0
`define DIV_RES 7
`define DIV_PRE_HI 6
`define DIV_PRE_LO 5
`define DIV_SCALE_HI 4
`define DIV_SCALE_LO 0

`define SRC_OFF 4'h0
`define SRC_SYS 4'h1
`define SRC_FAST 4'h2
`define SRC_EXT 4'h3
`define SRC_SLOW 4'h4
`define SRC_CMP 4'h5
`define SRC_PA0_R 4'h8
`define SRC_PA0_F 4'h9
`define SRC_PB0_R 4'hA
`define SRC_PB0_F 4'hB
`define SRC_PA4_R 4'hC
`define SRC_PA4_F 4'hD

`define PRE_LIM_1 6'h00
`define PRE_LIM_4 6'h03
`define PRE_LIM_16 6'h0F
`define PRE_LIM_64 6'h3F

`define TOP_8BIT 8'hFF
`define TOP_7BIT 8'h7F
`define TOP_6BIT 8'h3F

`endif

// ==== rtl/tpwm_pkg.sv ====
// Purpose: state types of the 8-bit timer block
// Assumes: constants come from tpwm_consts.svh
// Notes: one packed struct per module holds all of its state
package tpwm_pkg;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic [6:0] lvl;
  } src_state_t;

  typedef struct packed {
    logic [5:0] pre;
    logic [4:0] scale;
    byte_t cnt;
    logic tog;
    logic wave;
  } tmr_state_t;

  typedef struct packed {
    byte_t a_ctrl;
    byte_t a_div;
    byte_t a_bound;
    byte_t b_ctrl;
    byte_t b_div;
    byte_t b_bound;
    logic wr_pend;
    byte_t wr_idx;
    logic a_cnt_wr;
    logic b_cnt_wr;
    byte_t cnt_wdata;
    logic [31:0] hrdata;
    logic hready;
    logic a_wave;
    logic [1:0] a_route;
    logic [2:0] b_pin;
    logic [2:0] b_oe_n;
  } top_state_t;

endpackage : tpwm_pkg

// ==== rtl/count_source_sel.sv ====
// Purpose: turn the selected count source into a one-cycle count event
// Assumes: all source levels are synchronous to hclk
// Notes: an edge is seen as a change between two samples
`timescale 1ns/10ps
`include "tpwm_consts.svh"
module count_source_sel #(
  parameter bit CLOCK_DOUBLE_BUILD_OPTION = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] sel,
  input wire logic fast_internal_oscillator,
  input wire logic slow_internal_oscillator,
  input wire logic external_oscillator,
  input wire logic comparator_out,
  input wire logic port_a_line_zero,
  input wire logic port_b_line_zero,
  input wire logic port_a_line_four,
  input wire logic emulator_halt,
  output logic tick
);
  import tpwm_pkg::*;

  src_state_t s_q, s_d;
  logic [6:0] now;
  logic [6:0] rise;
  logic [6:0] fall;
  logic run;

  assign now = {port_a_line_four, port_b_line_zero, port_a_line_zero, comparator_out,
                slow_internal_oscillator, external_oscillator, fast_internal_oscillator};
  assign rise = now & ~s_q.lvl;
  assign fall = ~now & s_q.lvl;
  // only the fast oscillator keeps running through an emulator halt
  assign run = ~emulator_halt;

  always_comb begin
    s_d = s_q;
    s_d.lvl = now;
    unique case (sel)
      `SRC_SYS: tick = run;
      `SRC_FAST: tick = rise[0] | (CLOCK_DOUBLE_BUILD_OPTION & fall[0]);
      `SRC_EXT: tick = run & rise[1];
      `SRC_SLOW: tick = run & rise[2];
      `SRC_CMP: tick = run & rise[3];
      `SRC_PA0_R: tick = run & rise[4];
      `SRC_PA0_F: tick = run & fall[4];
      `SRC_PB0_R: tick = run & rise[5];
      `SRC_PB0_F: tick = run & fall[5];
      `SRC_PA4_R: tick = run & rise[6];
      `SRC_PA4_F: tick = run & fall[6];
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : count_source_sel

// ==== rtl/timer8_unit.sv ====
// Purpose: one 8-bit timer: pre-divider, scalar, counter and wave shaping
// Assumes: tick is a one-cycle count event
// Notes: a software count write wins over a count event in the same cycle
`timescale 1ns/10ps
`include "tpwm_consts.svh"
module timer8_unit #(
  parameter bit PWM_WIDTH_BUILD_OPTION = 1'b0,
  parameter bit COMPARATOR_GATE_BUILD_OPTION = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic [7:0] control,
  input wire logic [7:0] divider,
  input wire logic [7:0] bound,
  input wire logic comparator_out,
  input wire logic cnt_wr,
  input wire logic [7:0] cnt_wdata,
  output logic [7:0] count,
  output logic wave
);
  import tpwm_pkg::*;

  tmr_state_t t_q, t_d;
  logic [5:0] pre_lim;
  logic [4:0] scale_lim;
  logic div_tick;
  logic off;
  logic pwm;
  logic [7:0] top;
  logic raw;

  assign off = control[`CTL_SRC_HI:`CTL_SRC_LO] == `SRC_OFF;
  assign pwm = control[`CTL_MODE];
  assign scale_lim = divider[`DIV_SCALE_HI:`DIV_SCALE_LO];

  always_comb begin
    unique case (divider[`DIV_PRE_HI:`DIV_PRE_LO])
      2'h0: pre_lim = `PRE_LIM_1;
      2'h1: pre_lim = `PRE_LIM_4;
      2'h2: pre_lim = `PRE_LIM_16;
      2'h3: pre_lim = `PRE_LIM_64;
    endcase
  end

  // 6/7-bit width is fixed at build time
  assign top = !divider[`DIV_RES] ? `TOP_8BIT :
               (PWM_WIDTH_BUILD_OPTION ? `TOP_7BIT : `TOP_6BIT);
  assign div_tick = tick && t_q.pre == pre_lim && t_q.scale == scale_lim;

  always_comb begin
    t_d = t_q;
    if (tick) begin
      t_d.pre = (t_q.pre >= pre_lim) ? 6'h00 : t_q.pre + 6'h01;
      if (t_q.pre >= pre_lim) begin
        t_d.scale = (t_q.scale >= scale_lim) ? 5'h00 : t_q.scale + 5'h01;
      end
    end
    if (cnt_wr) begin
      t_d.cnt = cnt_wdata;
    end else if (div_tick) begin
      if (!pwm) begin
        if (t_q.cnt == bound) begin
          t_d.cnt = 8'h00;
          t_d.tog = ~t_q.tog;
        end else begin
          t_d.cnt = t_q.cnt + 8'h01;
        end
      end else begin
        t_d.cnt = (t_q.cnt >= top) ? 8'h00 : t_q.cnt + 8'h01;
      end
    end
    if (off) begin
      raw = 1'b0;
    end else if (!pwm) begin
      raw = t_q.tog;
    end else begin
      raw = (t_q.cnt <= bound) && !(COMPARATOR_GATE_BUILD_OPTION && comparator_out);
    end
    t_d.wave = raw ^ control[`CTL_INVERT];
  end

  assign count = t_q.cnt;
  assign wave = t_q.wave;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

endmodule : timer8_unit

// ==== rtl/tpwm_top.sv ====
// Purpose: two 8-bit timers with PWM, registers reached over AHB-Lite
// Assumes: all inputs synchronous to hclk; single word transfers only
// Notes: zero wait states; write-only registers and unmapped words read zero
`timescale 1ns/10ps
`include "tpwm_consts.svh"

module tpwm_top #(
  parameter bit PWM_WIDTH_BUILD_OPTION = 1'b0,
  parameter bit CLOCK_DOUBLE_BUILD_OPTION = 1'b0,
  parameter bit COMPARATOR_GATE_BUILD_OPTION = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic fast_internal_oscillator,
  input wire logic slow_internal_oscillator,
  input wire logic external_oscillator,
  input wire logic comparator_out,
  input wire logic port_a_line_zero,
  input wire logic port_b_line_zero,
  input wire logic port_a_line_four,
  input wire logic in_circuit_emulator_halt,
  output logic timer_a_wave,
  output logic [1:0] timer_a_route,
  output logic port_b_line_five_o,
  output logic port_b_line_five_oe_n,
  output logic port_b_line_six_o,
  output logic port_b_line_six_oe_n,
  output logic port_b_line_seven_o,
  output logic port_b_line_seven_oe_n
);
  import tpwm_pkg::*;

  top_state_t r_q, r_d;

  logic a_tick;
  logic b_tick;
  logic [7:0] a_count;
  logic [7:0] b_count;
  logic a_wave;
  logic b_wave;
  logic take;
  logic [7:0] idx;
  logic mapped;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;

  count_source_sel #(
    .CLOCK_DOUBLE_BUILD_OPTION(CLOCK_DOUBLE_BUILD_OPTION)
  ) u_src_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(r_q.a_ctrl[`CTL_SRC_HI:`CTL_SRC_LO]),
    .fast_internal_oscillator(fast_internal_oscillator),
    .slow_internal_oscillator(slow_internal_oscillator),
    .external_oscillator(external_oscillator),
    .comparator_out(comparator_out),
    .port_a_line_zero(port_a_line_zero),
    .port_b_line_zero(port_b_line_zero),
    .port_a_line_four(port_a_line_four),
    .emulator_halt(in_circuit_emulator_halt),
    .tick(a_tick)
  );

  count_source_sel #(
    .CLOCK_DOUBLE_BUILD_OPTION(CLOCK_DOUBLE_BUILD_OPTION)
  ) u_src_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(r_q.b_ctrl[`CTL_SRC_HI:`CTL_SRC_LO]),
    .fast_internal_oscillator(fast_internal_oscillator),
    .slow_internal_oscillator(slow_internal_oscillator),
    .external_oscillator(external_oscillator),
    .comparator_out(comparator_out),
    .port_a_line_zero(port_a_line_zero),
    .port_b_line_zero(port_b_line_zero),
    .port_a_line_four(port_a_line_four),
    .emulator_halt(in_circuit_emulator_halt),
    .tick(b_tick)
  );

  timer8_unit #(
    .PWM_WIDTH_BUILD_OPTION(PWM_WIDTH_BUILD_OPTION),
    .COMPARATOR_GATE_BUILD_OPTION(COMPARATOR_GATE_BUILD_OPTION)
  ) u_tmr_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(a_tick),
    .control(r_q.a_ctrl),
    .divider(r_q.a_div),
    .bound(r_q.a_bound),
    .comparator_out(comparator_out),
    .cnt_wr(r_q.a_cnt_wr),
    .cnt_wdata(r_q.cnt_wdata),
    .count(a_count),
    .wave(a_wave)
  );

  timer8_unit #(
    .PWM_WIDTH_BUILD_OPTION(PWM_WIDTH_BUILD_OPTION),
    .COMPARATOR_GATE_BUILD_OPTION(COMPARATOR_GATE_BUILD_OPTION)
  ) u_tmr_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(b_tick),
    .control(r_q.b_ctrl),
    .divider(r_q.b_div),
    .bound(r_q.b_bound),
    .comparator_out(comparator_out),
    .cnt_wr(r_q.b_cnt_wr),
    .cnt_wdata(r_q.cnt_wdata),
    .count(b_count),
    .wave(b_wave)
  );

  // address phase: only NONSEQ/SEQ to this slave while the bus is ready
  assign take = hsel && hready && htrans[1];
  assign idx = haddr[9:2];
  assign mapped = haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0;
  assign wbyte = hwdata[7:0];

  // read data is sampled at the address phase, so a read sees the count one cycle early
  always_comb begin
    rd_byte = 8'h00;
    if (mapped) begin
      unique case (idx)
        `IDX_TIMER_A_CONTROL: rd_byte = r_q.a_ctrl;
        `IDX_TIMER_A_COUNT: rd_byte = a_count;
        `IDX_TIMER_B_CONTROL: rd_byte = r_q.b_ctrl;
        `IDX_TIMER_B_COUNT: rd_byte = b_count;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_comb begin
    r_d = r_q;
    r_d.hready = 1'b1;
    r_d.a_cnt_wr = 1'b0;
    r_d.b_cnt_wr = 1'b0;
    // data phase of a write: hwdata is valid now
    if (r_q.wr_pend) begin
      unique case (r_q.wr_idx)
        `IDX_TIMER_A_BOUND: r_d.a_bound = wbyte;
        `IDX_TIMER_A_DIVIDER: r_d.a_div = wbyte;
        `IDX_TIMER_A_CONTROL: r_d.a_ctrl = wbyte;
        `IDX_TIMER_A_COUNT: begin
          r_d.a_cnt_wr = 1'b1;
          r_d.cnt_wdata = wbyte;
        end
        `IDX_TIMER_B_CONTROL: r_d.b_ctrl = wbyte;
        `IDX_TIMER_B_COUNT: begin
          r_d.b_cnt_wr = 1'b1;
          r_d.cnt_wdata = wbyte;
        end
        `IDX_TIMER_B_DIVIDER: r_d.b_div = wbyte;
        `IDX_TIMER_B_BOUND: r_d.b_bound = wbyte;
        default: r_d.wr_pend = 1'b0;
      endcase
    end
    r_d.wr_pend = take && hwrite && mapped;
    r_d.wr_idx = idx;
    if (take && !hwrite) begin
      r_d.hrdata = {24'h000000, rd_byte};
    end
    r_d.a_wave = a_wave;
    r_d.a_route = r_q.a_ctrl[`CTL_ROUTE_HI:`CTL_ROUTE_LO];
    // second timer drives only the pin its route code names
    unique case (r_q.b_ctrl[`CTL_ROUTE_HI:`CTL_ROUTE_LO])
      2'h0: begin
        r_d.b_pin = 3'h0;
        r_d.b_oe_n = 3'h7;
      end
      2'h1: begin
        r_d.b_pin = {2'h0, b_wave};
        r_d.b_oe_n = 3'h6;
      end
      2'h2: begin
        r_d.b_pin = {1'b0, b_wave, 1'b0};
        r_d.b_oe_n = 3'h5;
      end
      2'h3: begin
        r_d.b_pin = {b_wave, 2'h0};
        r_d.b_oe_n = 3'h3;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_q <= '0;
      r_q.a_ctrl <= `RST_BYTE;
      r_q.b_ctrl <= `RST_BYTE;
      r_q.hready <= 1'b1;
      r_q.b_oe_n <= 3'h7;
    end else begin
      r_q <= r_d;
    end
  end

  assign hrdata = r_q.hrdata;
  assign hreadyout = r_q.hready;
  // every transfer is answered OKAY
  assign hresp = 1'b0;
  assign timer_a_wave = r_q.a_wave;
  assign timer_a_route = r_q.a_route;
  assign port_b_line_five_o = r_q.b_pin[0];
  assign port_b_line_five_oe_n = r_q.b_oe_n[0];
  assign port_b_line_six_o = r_q.b_pin[1];
  assign port_b_line_six_oe_n = r_q.b_oe_n[1];
  assign port_b_line_seven_o = r_q.b_pin[2];
  assign port_b_line_seven_oe_n = r_q.b_oe_n[2];

endmodule : tpwm_top

// ==== sim/tpwm_sva.sv ====
// Purpose: bus and pin checks on the two 8-bit timers
// Assumes: writes only to mapped words; default build options
// Notes: control writes are shadowed so settled pin states can be judged
`timescale 1ns/10ps
`include "tpwm_consts.svh"
module tpwm_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic timer_a_wave,
  input wire logic [1:0] timer_a_route,
  input wire logic port_b_line_five_o,
  input wire logic port_b_line_five_oe_n,
  input wire logic port_b_line_six_o,
  input wire logic port_b_line_six_oe_n,
  input wire logic port_b_line_seven_o,
  input wire logic port_b_line_seven_oe_n
);
  logic tk_q;
  logic [7:0] ix_q;
  logic [7:0] a_ctl;
  logic [7:0] b_ctl;
  logic [2:0] age;
  wire logic [3:0] sel4 = 4'h1 << b_ctl[3:2];
  wire logic [2:0] oe_n = {port_b_line_seven_oe_n, port_b_line_six_oe_n, port_b_line_five_oe_n};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // age saturates so outputs get several cycles to settle after a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tk_q <= 1'b0;
      ix_q <= 8'h00;
      a_ctl <= 8'h00;
      b_ctl <= 8'h00;
      age <= 3'h0;
    end else begin
      tk_q <= hsel && hready && htrans[1] && hwrite;
      ix_q <= haddr[9:2];
      if (tk_q && ix_q == `IDX_TIMER_A_CONTROL) a_ctl <= hwdata[7:0];
      if (tk_q && ix_q == `IDX_TIMER_B_CONTROL) b_ctl <= hwdata[7:0];
      age <= tk_q ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
    end
  end
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("bus ready dropped");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_wo_read_zero: assert property (hsel && hready && htrans[1] && !hwrite &&
      haddr inside {32'h0, 32'h24, 32'h5C, 32'hD0, 32'hD4} |=> hrdata == 32'h0)
    else $error("write-only or unmapped word read nonzero");
  a_pin_one_hot: assert property ($countones(~oe_n) <= 1)
    else $error("more than one port b pin driven");
  a_pin_idle_low: assert property (!((port_b_line_five_oe_n && port_b_line_five_o) ||
      (port_b_line_six_oe_n && port_b_line_six_o) || (port_b_line_seven_oe_n && port_b_line_seven_o)))
    else $error("undriven pin shows a level");
  a_route_a: assert property (age == 3'h7 |-> timer_a_route == a_ctl[3:2])
    else $error("timer a route differs from control");
  a_pin_route_b: assert property (age == 3'h7 |-> oe_n == ~sel4[3:1])
    else $error("port b enables differ from control");
  a_off_wave: assert property (age == 3'h7 && a_ctl[7:4] == 4'h0 |-> timer_a_wave == a_ctl[0])
    else $error("stopped timer a output not at inactive level");
  a_b_off_wave: assert property (age == 3'h7 && b_ctl[7:2] == 6'h01 |->
      port_b_line_five_o == b_ctl[0])
    else $error("stopped timer b output not at inactive level");
endmodule : tpwm_sva

bind tpwm_top tpwm_sva chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timer_a_wave(timer_a_wave),
  .timer_a_route(timer_a_route), .port_b_line_five_o(port_b_line_five_o),
  .port_b_line_five_oe_n(port_b_line_five_oe_n), .port_b_line_six_o(port_b_line_six_o),
  .port_b_line_six_oe_n(port_b_line_six_oe_n), .port_b_line_seven_o(port_b_line_seven_o),
  .port_b_line_seven_oe_n(port_b_line_seven_oe_n));

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench of the two 8-bit timers
// Assumes: default build options, so reduced resolution is 6-bit
// Notes: source levels are random; the system clock source gives exact timing
`timescale 1ns/10ps
`include "tpwm_consts.svh"
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic halt = 1'b0;
  logic halt_v = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] st = 32'h51;
  logic [31:0] sa = 32'h51;
  logic [6:0] lv = 7'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, wa;
  logic [1:0] ra;
  logic [2:0] pb_o, pb_oe_n;
  wire logic hready = hreadyout;
  logic [7:0] ix [10] = '{`IDX_TIMER_A_CONTROL, `IDX_TIMER_A_COUNT, `IDX_TIMER_A_BOUND,
    `IDX_TIMER_A_DIVIDER, `IDX_TIMER_B_CONTROL, `IDX_TIMER_B_COUNT, `IDX_TIMER_B_BOUND,
    `IDX_TIMER_B_DIVIDER, 8'h00, 8'h3F};
  // corner cases: full-high 6-bit, full-high 8-bit, inverted minimum, slow period
  logic [23:0] cfg [4] = '{24'h12803F, 24'h1200FF, 24'h130000, 24'h106000};
  int fail_count = 0;
  int cmp_count = 0;

  always #2 hclk = ~hclk;

  tpwm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fast_internal_oscillator(lv[0]),
    .slow_internal_oscillator(lv[1]), .external_oscillator(lv[2]), .comparator_out(lv[3]),
    .port_a_line_zero(lv[4]), .port_b_line_zero(lv[5]), .port_a_line_four(lv[6]),
    .in_circuit_emulator_halt(halt), .timer_a_wave(wa), .timer_a_route(ra),
    .port_b_line_five_o(pb_o[0]), .port_b_line_five_oe_n(pb_oe_n[0]),
    .port_b_line_six_o(pb_o[1]), .port_b_line_six_oe_n(pb_oe_n[1]),
    .port_b_line_seven_o(pb_o[2]), .port_b_line_seven_oe_n(pb_oe_n[2]));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // source levels draw from their own sequence so the bench stays repeatable
  always @(posedge hclk) begin
    sa = xs(sa);
    lv <= sa[6:0];
    halt <= halt_v;
  end

  function automatic int per(input logic [7:0] c, input logic [7:0] k, input logic [7:0] d);
    int m;
    m = (1 << (2 * d[6:5])) * (d[4:0] + 1);
    return c[1] ? (d[7] ? 64 : 256) * m : 2 * (k + 1) * m;
  endfunction : per

  function automatic int exp_hi(input logic [7:0] c, input logic [7:0] k, input logic [7:0] d);
    int h;
    h = c[1] ? (k + 1) * per(c, k, d) / (d[7] ? 64 : 256) : per(c, k, d) / 2;
    return c[0] ? per(c, k, d) - h : h;
  endfunction : exp_hi

  function automatic bit runs(input logic [3:0] s, input logic h);
    return h ? (s == 4'h2) : (s inside {[4'h1:4'h5], [4'h8:4'hD]});
  endfunction : runs

  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic bus(input logic w_en, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w_en;
    haddr <= {22'h0, idx, 2'h0};
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 20) begin
      fail_count++;
      $display("Error bus ready expected high seen timeout");
      print_verdict();
    end
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr

  task automatic meas(input int w, input bit b, output int hi, output int ed);
    logic p, c;
    hi = 0;
    ed = 0;
    p = b ? pb_o[0] : wa;
    repeat (w) begin
      @(posedge hclk);
      c = b ? pb_o[0] : wa;
      hi += int'(c === 1'b1);
      ed += int'(c !== p);
      p = c;
    end
  endtask : meas

  initial begin
    logic [31:0] r, a, b;
    logic [7:0] c, d, k, v;
    int hi, ed, w, t;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, ix[i], 8'h00, r);
      chk("reset read", 32'h0, r);
    end
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      // stopped timers with the invert bit show a high inactive level
      v = 8'(i << 2) | 8'(i != 0);
      wr(ix[0], v);
      wr(ix[4], v);
      repeat (8) @(posedge hclk);
      chk("route a", 32'(i), 32'(ra));
      chk("pin enables", 32'(i == 0 ? 3'h7 : 3'h7 ^ (3'h1 << (i - 1))), 32'(pb_oe_n));
      chk("pin levels", 32'(i == 0 ? 3'h0 : 3'h1 << (i - 1)), 32'(pb_o));
      chk("stopped wave a", 32'(i != 0), 32'(wa));
      bus(1'b0, ix[4], 8'h00, r);
      chk("control readback", {24'h0, v}, r);
    end
    $display("test output routing done");
    for (int i = 0; i < 16; i++) begin
      st = xs(st);
      r = st;
      c = {6'h04, r[1], r[0]};
      // pre-divider only in period mode keeps long PWM periods inside the cycle budget
      d = {r[2] & r[0], (r[0] | r[1]) ? 2'h0 : r[4:3], 4'h0, r[5]};
      k = r[0] ? (d[7] ? {2'h0, r[13:8]} : r[15:8]) : {6'h0, r[9:8]};
      if (i < 4) {c, d, k} = cfg[i];
      t = i[0] ? 4 : 0;
      wr(ix[t], 8'h00);
      wr(ix[t + 1], 8'h00);
      wr(ix[t + 2], k);
      bus(1'b0, ix[t + 2], 8'h00, r);
      chk("write-only read", 32'h0, r);
      wr(ix[t + 3], d);
      wr(ix[t], c | (i[0] ? 8'h04 : 8'h00));
      w = per(c, k, d);
      repeat (w) @(posedge hclk);
      meas(w, i[0], hi, ed);
      chk("high cycles", 32'(exp_hi(c, k, d)), 32'(hi));
      w = exp_hi(c, k, d) % w == 0 ? 0 : 2;
      chk("edges per period", 32'(w), 32'(ed));
    end
    $display("test waveforms done");
    wr(ix[3], 8'h00);
    for (int i = 0; i < 32; i++) begin
      halt_v <= i[4];
      wr(ix[0], 8'h00);
      st = xs(st);
      wr(ix[1], st[7:0]);
      repeat (2) @(posedge hclk);
      bus(1'b0, ix[1], 8'h00, a);
      chk("count readback", {24'h0, st[7:0]}, a);
      wr(ix[0], {i[3:0], 4'h2});
      repeat (40) @(posedge hclk);
      bus(1'b0, ix[1], 8'h00, a);
      repeat (40) @(posedge hclk);
      bus(1'b0, ix[1], 8'h00, b);
      chk("count moves", 32'(runs(i[3:0], i[4])), 32'(a !== b));
    end
    halt_v <= 1'b0;
    $display("test count sources done");
    print_verdict();
  end
endmodule : tb_top
